// *** rtl/usa_pkg.sv ***
// Package for the microstore access ports: widths, field positions, codes.
// Assumes a single 100 MHz clock domain and synchronous pin inputs.
`default_nettype none
package usa_pkg;
    localparam int BUS_W = 36;
    localparam int DATA_W = 32;
    localparam int PAR_LSB = 32;
    localparam int PAR_W = 4;
    localparam int UI_W = 64;
    localparam int UI_PAR_LSB = 56;
    localparam int ADDR_W = 16;
    localparam int RAM_AW_SMALL = 10;
    localparam int RAM_AW_LARGE = 12;
    localparam int SEL_LSB = 12;
    localparam int ERR_LSB = 14;
    localparam int RANGE_LSB = 10;
    localparam int ROM_AW = 12;
    localparam int ROM_LOC_AW = 10;
    localparam int SW_W = 6;
    // Range switch codes, 1 = open
    localparam logic [5:0] SW_1K = 6'h2A;
    localparam logic [5:0] SW_2K = 6'h29;
    localparam logic [5:0] SW_3K = 6'h25;
    localparam logic [5:0] SW_4K = 6'h15;
    localparam logic [1:0] RANGE_COUNT_1K = 2'h0;

    typedef struct packed {
        logic port_enable_n;
        logic port_read_write;
        logic pulse_addr_latch_n;
        logic pulse_low_half_n;
        logic pulse_high_half_n;
    } usa_port_ctl_t;

    typedef struct packed {
        logic data_valid_n;
        logic drive;
        logic [UI_W-1:0] data;
    } usa_ustore_out_t;
endpackage
`default_nettype wire

// *** rtl/usa_ram.sv ***
// Writable microstore RAM with two 32-bit half write strobes.
// Read data leaves through a register; one read port, one write port.
`default_nettype none
module usa_ram #(
    parameter int AW = 12
) (
    input wire logic i_clk,
    input wire logic [AW-1:0] i_waddr,
    input wire logic i_we_low,
    input wire logic i_we_high,
    input wire logic [31:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [63:0] o_rdata
);
    logic [63:0] mem_q [0:(1<<AW)-1];
    logic [63:0] rdata_q;

    always_ff @(posedge i_clk) begin
        if (i_we_low) begin
            mem_q[i_waddr][31:0] <= i_wdata;
        end
        if (i_we_high) begin
            mem_q[i_waddr][63:32] <= i_wdata;
        end
        rdata_q <= mem_q[i_raddr];
    end

    assign o_rdata = rdata_q;
endmodule
`default_nettype wire

// *** rtl/usa_rom_decode.sv ***
// Read-only microstore address decode: range check, board select, errors.
// Contents arrive as a plain port so the board image stays outside.
`default_nettype none
module usa_rom_decode (
    input wire logic [15:0] i_addr,
    input wire logic [5:0] i_range_sw,
    input wire logic [1:0] i_board_addr,
    output logic o_board_hit,
    output logic o_invalid,
    output logic [9:0] o_loc
);
    logic [3:0] range_onehot;
    logic [3:0] range_ok;
    logic [1:0] rng;

    // Address bits 16/17 carry parity and never reach this logic
    assign o_loc = i_addr[usa_pkg::ROM_LOC_AW-1:0];
    assign rng = i_addr[usa_pkg::RANGE_LSB +: 2];
    assign range_onehot = 4'h1 << rng;
    // Range 0 is always wired to the memory enable
    assign range_ok[0] = 1'b1;
    assign range_ok[1] = (i_range_sw != usa_pkg::SW_1K);
    assign range_ok[2] = (i_range_sw == usa_pkg::SW_3K) ||
        (i_range_sw == usa_pkg::SW_4K);
    assign range_ok[3] = (i_range_sw == usa_pkg::SW_4K);
    assign o_board_hit =
        (i_addr[usa_pkg::SEL_LSB +: 2] == i_board_addr);
    assign o_invalid = (|i_addr[usa_pkg::ERR_LSB +: 2]) ||
        !(|(range_onehot & range_ok));
endmodule
`default_nettype wire

// *** rtl/usa_top.sv ***
// Top of the microstore access ports: maintenance bus port onto the
// writable store, and the read-only store decode onto the microstore bus.
// Assumes all pins synchronous to i_clk; pulse points are sampled levels.
`default_nettype none
module usa_top #(
    parameter int RAM_AW = 12,
    parameter logic [15:0] STORE_SEL = 16'h0000
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire usa_pkg::usa_port_ctl_t i_port_ctl,
    input wire logic [35:0] i_maint_gate_bus,
    output logic [35:0] o_maint_gate_bus,
    output logic o_maint_gate_bus_oe,
    output logic o_addr_ack_n,
    input wire logic i_write_en_low,
    input wire logic i_write_en_high,
    input wire logic i_half_select,
    output logic o_read_go_n,
    input wire logic [15:0] i_ustore_addr_bus,
    input wire logic [5:0] i_range_sw,
    input wire logic [1:0] i_board_addr,
    input wire logic [63:0] i_rom_data,
    input wire logic i_maint_data_release,
    output logic [9:0] o_rom_loc,
    output usa_pkg::usa_ustore_out_t o_ustore
);
    // Only the small and large store depths have a defined select field
    if (RAM_AW != usa_pkg::RAM_AW_SMALL &&
        RAM_AW != usa_pkg::RAM_AW_LARGE) begin : g_bad_aw
        $error("RAM_AW must be 10 or 12");
    end

    logic [RAM_AW-1:0] port_addr_latch_q, port_addr_latch_d;
    logic latch_en_q, latch_en_d;
    logic ack_n_q, ack_n_d;
    logic addr_ok, latch_pulse, write_en, read_en;
    logic we_low, we_high, low_act, high_act, read_go;
    logic [63:0] ram_rdata;
    logic [7:0] ram_par;
    logic par_gen;
    logic [3:0] par_sel;
    logic [31:0] data_sel;
    logic [35:0] bus_d;
    logic [35:0] bus_q;
    logic oe_q, read_go_n_q;
    logic board_hit, rom_invalid;
    logic [9:0] rom_loc;
    usa_pkg::usa_ustore_out_t ustore_d, ustore_q;
    logic [9:0] rom_loc_q;

    // Bits above the RAM index select this store and must match
    assign addr_ok = (i_maint_gate_bus[15:RAM_AW] ==
        STORE_SEL[15:RAM_AW]);
    assign latch_pulse = !i_port_ctl.port_enable_n &&
        !i_port_ctl.pulse_addr_latch_n && addr_ok;
    assign port_addr_latch_d = latch_pulse ?
        i_maint_gate_bus[RAM_AW-1:0] : port_addr_latch_q;
    assign ack_n_d = !latch_pulse;
    assign latch_en_d = i_port_ctl.port_enable_n ? 1'b0 :
        (latch_pulse ? 1'b1 : latch_en_q);
    // Low read/write selects write; the address phase itself is read
    assign write_en = latch_en_q && !i_port_ctl.port_read_write;
    assign read_en = latch_en_q && i_port_ctl.port_read_write;
    assign low_act = !i_port_ctl.pulse_low_half_n;
    assign high_act = !i_port_ctl.pulse_high_half_n;
    assign we_low = low_act && write_en && i_write_en_low;
    assign we_high = high_act && write_en && i_write_en_high;
    assign read_go = (low_act || high_act) && read_en;

    usa_ram #(
        .AW(RAM_AW)
    ) u_ram (
        .i_clk(i_clk),
        .i_waddr(port_addr_latch_q),
        .i_we_low(we_low),
        .i_we_high(we_high),
        .i_wdata(i_maint_gate_bus[usa_pkg::DATA_W-1:0]),
        .i_raddr(port_addr_latch_q),
        .o_rdata(ram_rdata)
    );

    assign ram_par = ram_rdata[usa_pkg::UI_PAR_LSB +: 8];
    // Odd parity bit over the stored parity byte
    assign par_gen = ~(^ram_par);
    assign par_sel = i_half_select ?
        {par_gen, ram_par[6:4]} : ram_par[3:0];
    assign data_sel = i_half_select ?
        ram_rdata[63:32] : ram_rdata[31:0];
    assign bus_d = {par_sel, data_sel};

    usa_rom_decode u_dec (
        .i_addr(i_ustore_addr_bus),
        .i_range_sw(i_range_sw),
        .i_board_addr(i_board_addr),
        .o_board_hit(board_hit),
        .o_invalid(rom_invalid),
        .o_loc(rom_loc)
    );

    assign ustore_d.data_valid_n = rom_invalid;
    // Release from the maintenance channel beats any valid read
    assign ustore_d.drive = board_hit && !rom_invalid &&
        !i_maint_data_release;
    assign ustore_d.data = ustore_d.drive ? i_rom_data : 64'h0;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            port_addr_latch_q <= '0;
            latch_en_q <= 1'b0;
            ack_n_q <= 1'b1;
            read_go_n_q <= 1'b1;
            oe_q <= 1'b0;
            bus_q <= 36'h0;
            ustore_q <= '0;
            rom_loc_q <= 10'h0;
        end else begin
            port_addr_latch_q <= port_addr_latch_d;
            latch_en_q <= latch_en_d;
            ack_n_q <= ack_n_d;
            read_go_n_q <= !read_go;
            oe_q <= read_go;
            bus_q <= bus_d;
            ustore_q <= ustore_d;
            rom_loc_q <= rom_loc;
        end
    end

    assign o_maint_gate_bus = bus_q;
    assign o_maint_gate_bus_oe = oe_q;
    assign o_addr_ack_n = ack_n_q;
    assign o_read_go_n = read_go_n_q;
    assign o_ustore = ustore_q;
    assign o_rom_loc = rom_loc_q;
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Testbench for usa_top: decode table, maintenance writes and reads.
// Assumes usa_far as far side and usa_chk bound onto the design.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [15:0] a; logic [5:0] s; logic [1:0] b; logic v;
    } usa_row_t;
    localparam logic [31:0] L = 32'hA5A5_0F0F, H = 32'h9C76_5432;
    localparam logic [15:0] A = 16'h0F23;
    logic i_clk = 0, i_sys_rst = 1, moe, doe, ackn, wel, weh, hs, gon, rel;
    logic [35:0] mbus, w, dbus;
    logic [15:0] ua;
    logic [5:0] sw;
    logic [1:0] brd;
    logic [63:0] rom;
    logic [9:0] loc;
    usa_pkg::usa_port_ctl_t ctl;
    usa_pkg::usa_ustore_out_t us;
    int fail_count = 0, compares = 0;
    usa_row_t rows [10] = '{'{16'h0005, 6'h2A, 0, 0}, '{16'h0405, 6'h2A, 0, 1},
        '{16'h0405, 6'h29, 0, 0}, '{16'h0805, 6'h29, 0, 1},
        '{16'h0805, 6'h25, 0, 0}, '{16'h0C05, 6'h25, 0, 1},
        '{16'h0FFF, 6'h15, 0, 0}, '{16'h4000, 6'h15, 0, 1},
        '{16'h8000, 6'h15, 0, 1}, '{16'h3C0A, 6'h15, 3, 0}};
    always #5 i_clk = ~i_clk;
    usa_top usa_top_inst (.i_clk, .i_sys_rst, .i_port_ctl(ctl),
        .i_maint_gate_bus(w), .o_maint_gate_bus(dbus),
        .o_maint_gate_bus_oe(doe), .o_addr_ack_n(ackn), .i_write_en_low(wel),
        .i_write_en_high(weh), .i_half_select(hs), .o_read_go_n(gon),
        .i_ustore_addr_bus(ua), .i_range_sw(sw), .i_board_addr(brd),
        .i_rom_data(rom), .i_maint_data_release(rel), .o_rom_loc(loc),
        .o_ustore(us));
    usa_far usa_far_inst (.i_clk, .i_addr(ua[9:0]), .o_rom(rom),
        .i_dev_oe(doe), .i_dev_bus(dbus), .i_mst_oe(moe), .i_mst_bus(mbus),
        .o_wire(w));
    task automatic chk(string n, logic [71:0] s, logic [71:0] e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Control word order: enable_n, read_write, latch, low, high pulses
    task automatic pp(logic [4:0] c, logic [35:0] b, logic o, int n);
        ctl = c;
        mbus = b;
        moe = o;
        repeat (n) @(negedge i_clk);
    endtask
    task automatic latch(logic [15:0] a, logic ack);
        pp(5'b01011, {20'h0, a}, 1, 1);
        chk("ack", ackn, !ack);
    endtask
    task automatic wr(logic hi, logic [31:0] d, logic en);
        wel = en & !hi;
        weh = en & hi;
        latch(A, 1);
        pp(hi ? 5'b00110 : 5'b00101, {4'h0, d}, 1, 1);
        pp(5'b11111, 36'h0, 0, 1);
    endtask
    task automatic rd(logic h, logic [35:0] e);
        latch(A, 1);
        hs = h;
        pp(h ? 5'b01110 : 5'b01101, 36'h0, 0, 3);
        chk("go", {gon, doe}, 2'b01);
        chk("rd", w, e);
        pp(5'b11111, 36'h0, 0, 1);
    endtask
    initial begin
        #200us;
        fail_count++;
        stop_test();
    end
    initial begin
        {wel, weh, hs, rel, brd, ua} = '0;
        sw = 6'h2A;
        pp(5'b11111, 36'h0, 0, 16);
        chk("rst", {ackn, gon, doe, us}, {3'b110, 66'h0});
        i_sys_rst = 0;
        foreach (rows[k]) begin
            {ua, sw, brd} = {rows[k].a, rows[k].s, rows[k].b};
            @(negedge i_clk);
            chk("valid", us.data_valid_n, rows[k].v);
            chk("loc", loc, ua[9:0]);
            if (!rows[k].v)
                chk("word", {us.drive, us.data},
                    {1'b1, ua[9:0], 22'h0, ~ua[9:0], 22'h0});
        end
        {ua, brd, rel} = {16'h0005, 2'h0, 1'b1};
        @(negedge i_clk);
        chk("release", us.drive, 0);
        {brd, rel} = 3'b010;
        @(negedge i_clk);
        chk("board", us.drive, 0);
        latch(16'h1023, 0);
        pp(5'b11111, 36'h0, 0, 1);
        wr(0, L, 1);
        wr(1, H, 1);
        wr(0, 32'h1111_1111, 0);
        rd(0, {H[27:24], L});
        rd(1, {~^H[31:24], H[30:28], H});
        stop_test();
    end
endmodule
`default_nettype wire

// *** tb/usa_chk.sv ***
// Checker for the microstore access ports, bound onto usa_top.
// Assumes one clock domain and the synchronous active-high reset.
`default_nettype none
module usa_chk (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire usa_pkg::usa_port_ctl_t i_port_ctl,
    input wire logic [35:0] i_maint_gate_bus,
    input wire logic o_maint_gate_bus_oe,
    input wire logic o_addr_ack_n,
    input wire logic o_read_go_n,
    input wire logic [15:0] i_ustore_addr_bus,
    input wire logic [1:0] i_board_addr,
    input wire logic i_maint_data_release,
    input wire logic [9:0] o_rom_loc,
    input wire usa_pkg::usa_ustore_out_t o_ustore
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic take;
    logic idle;
    assign take = !i_port_ctl.port_enable_n
        && !i_port_ctl.pulse_addr_latch_n && i_maint_gate_bus[15:12] == 4'h0;
    assign idle = i_port_ctl.pulse_low_half_n && i_port_ctl.pulse_high_half_n;
    sequence s_take;
        take;
    endsequence
    sequence s_rd_pulse;
        i_port_ctl.port_read_write && !idle;
    endsequence
    property p_ack;
        s_take |=> !o_addr_ack_n;
    endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_nack;
        !take |=> o_addr_ack_n;
    endproperty
    a_nack: assert property (p_nack) else $error("stray ack");
    property p_go;
        $fell(o_read_go_n) |->
            $past(i_port_ctl.port_read_write && !idle);
    endproperty
    a_go: assert property (p_go) else $error("read-go uncaused");
    property p_go_off;
        idle |=> o_read_go_n;
    endproperty
    a_go_off: assert property (p_go_off) else $error("read-go held");
    property p_oe;
        o_maint_gate_bus_oe == !o_read_go_n;
    endproperty
    a_oe: assert property (p_oe) else $error("bus drive off read-go");
    property p_rel;
        i_maint_data_release |=> !o_ustore.drive;
    endproperty
    a_rel: assert property (p_rel) else $error("drive on release");
    property p_hi;
        |i_ustore_addr_bus[15:14] |=> o_ustore.data_valid_n;
    endproperty
    a_hi: assert property (p_hi) else $error("top bits not invalid");
    property p_loc;
        1'b1 |=> o_rom_loc == $past(i_ustore_addr_bus[9:0]);
    endproperty
    a_loc: assert property (p_loc) else $error("location wrong");
    property p_r0;
        i_ustore_addr_bus[15:10] == {2'h0, i_board_addr, 2'h0}
        && !i_maint_data_release |=> o_ustore.drive && !o_ustore.data_valid_n;
    endproperty
    a_r0: assert property (p_r0) else $error("range 0 refused");
endmodule
bind usa_top usa_chk usa_chk_inst (.i_clk, .i_sys_rst, .i_port_ctl,
    .i_maint_gate_bus, .o_maint_gate_bus_oe, .o_addr_ack_n, .o_read_go_n,
    .i_ustore_addr_bus, .i_board_addr, .i_maint_data_release, .o_rom_loc,
    .o_ustore);
`default_nettype wire

// *** tb/usa_far.sv ***
// Far side: PROM image for the read-only store and the maintenance wire.
// Assumes the master drives the wire only while its enable is high.
`default_nettype none
module usa_far (
    input wire logic i_clk,
    input wire logic [9:0] i_addr,
    output logic [63:0] o_rom,
    input wire logic i_dev_oe,
    input wire logic [35:0] i_dev_bus,
    input wire logic i_mst_oe,
    input wire logic [35:0] i_mst_bus,
    output logic [35:0] o_wire
);
    logic [35:0] last_q;
    // Word depends on location so a wrong fetch cannot match
    assign o_rom = {i_addr, 22'h0, ~i_addr, 22'h0};
    // Released wire shows the inverse of its last level, never a stale copy
    assign o_wire = i_dev_oe ? i_dev_bus : i_mst_oe ? i_mst_bus : ~last_q;
    always_ff @(posedge i_clk) last_q <= o_wire;
endmodule
`default_nettype wire
